/* shared/sprc_pkg.sv */
package sprc_pkg;

    // Control register layout
    localparam int          CTRL_W          = 16;
    localparam int          CTRL_ON_BIT     = 15;
    localparam int          CTRL_STOP_BIT   = 13;
    localparam int          CTRL_MASTER_BIT = 5;
    localparam int          CTRL_RXEN_BIT   = 4;
    localparam int          CTRL_PRIO_LSB   = 0;
    localparam int          PRIO_W          = 3;
    localparam logic [15:0] CTRL_RESET      = 16'h0000;

    // Status register layout
    localparam int          STAT_W          = 16;
    localparam int          STAT_RBF_BIT    = 0;
    localparam int          STAT_TBF_BIT    = 1;
    localparam int          STAT_OVF_BIT    = 6;
    localparam int          STAT_BUSY_BIT   = 11;
    localparam logic [15:0] STAT_RESET      = 16'h0000;

    // Defaults of the transfer datapath
    localparam int          DATA_W_DEF      = 8;
    localparam int          RATE_W_DEF      = 8;

    // Event flags, one bit per event
    typedef struct packed {
        logic error;
        logic rx;
        logic tx;
    } sprc_evt_t;

    // Power and debug state of the chip
    typedef struct packed {
        logic sleep;
        logic idle;
        logic debug;
    } sprc_pwr_t;

    // Master sequencer states
    typedef enum logic [0:0] {
        M_IDLE = 1'b0,
        M_RUN  = 1'b1
    } sprc_mstate_t;

endpackage

/* rtl/sprc_sync.sv */
`timescale 1ns/10ps
module sprc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    // Asynchronous levels in, filtered levels out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] ff1;
        logic [WIDTH-1:0] ff2;
        logic [WIDTH-1:0] ff3;
        logic [WIDTH-1:0] q;
    } sprc_sync_st_t;

    sprc_sync_st_t st_reg;
    sprc_sync_st_t st_next;

    // Three stages; a bit moves once the second and third stages agree
    always_comb begin
        st_next     = st_reg;
        st_next.ff1 = d_i;
        st_next.ff2 = st_reg.ff1;
        st_next.ff3 = st_reg.ff2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_reg.ff2[i] == st_reg.ff3[i]) begin
                st_next.q[i] = st_reg.ff3[i];
            end
        end
        if (reset_i) begin
            st_next = '0;
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        st_reg <= st_next;
    end

    assign q_o = st_reg.q;

endmodule

/* rtl/sprc_core.sv */
`timescale 1ns/10ps
// Function
// [RQ1] Master: rate generator stops while the chip sleeps.
// [RQ2] Master: a transfer running when sleep starts is dropped, not resumed.
// [RQ3] Master: no new transfer starts during sleep.
// [RQ4] Software should let a master transfer finish before sleeping.
// [RQ5] Slave: keeps shifting on the outside clock through sleep.
// [RQ6] Finished slave word sets buffer-full flag and receive event.
// [RQ7] Receive event in sleep wakes chip if enabled and priority above CPU.
// [RQ8] Slave: sleep entry or exit leaves all registers untouched.
// [RQ9] Master in idle: stop bit 13 set stops as in sleep, clear runs.
// [RQ10] Slave: runs on in idle regardless of stop bit, as in sleep.
// [RQ11] Data reads in debug state change no status bit.
// [RQ12] Device reset clears control and status registers.
// [RQ13] Device reset empties transmit and receive buffers.
// [RQ14] Device reset returns the rate generator to its start.
// [RQ15] Power-on reset forces all registers to reset values.
// [RQ16] Watchdog reset forces all registers to reset values.
// [RQ17] Event flags set whatever the enables hold, for polling.
// [RQ18] Aborted master word raises no buffer-full flag nor receive event.
module sprc_core #(
    parameter int DATA_W = sprc_pkg::DATA_W_DEF,
    parameter int RATE_W = sprc_pkg::RATE_W_DEF
) (
    // Clock and resets
    input  wire logic                    clock_i,
    input  wire logic                    reset_i,
    input  wire logic                    por_reset_i,
    input  wire logic                    wdt_reset_i,
    // Configuration writes
    input  wire logic                    ctrl_wr_i,
    input  wire logic [15:0]             ctrl_data_i,
    input  wire logic                    rate_wr_i,
    input  wire logic [RATE_W-1:0]       rate_data_i,
    // Data buffer access and event clearing
    input  wire logic                    tx_wr_i,
    input  wire logic [DATA_W-1:0]       tx_data_i,
    input  wire logic                    rx_rd_i,
    input  wire sprc_pkg::sprc_evt_t     evt_clr_i,
    // Chip power state
    input  wire sprc_pkg::sprc_pwr_t     pwr_i,
    input  wire logic [2:0]              cpu_prio_i,
    // Register and event view
    output logic      [15:0]             ctrl_o,
    output logic      [15:0]             status_o,
    output logic      [DATA_W-1:0]       rx_data_o,
    output sprc_pkg::sprc_evt_t          evt_o,
    output logic                         wake_o,
    // Serial link
    input  wire logic                    sck_i,
    output logic                         sck_o,
    output logic                         sck_oe_o,
    input  wire logic                    ss_n_i,
    input  wire logic                    sdi_i,
    output logic                         sdo_o,
    output logic                         sdo_oe_o,
    output logic                         sdo_slave_o
);

    localparam int                CNT_W    = $clog2(DATA_W);
    localparam logic [CNT_W-1:0]  LAST_BIT = CNT_W'(DATA_W - 1);
    localparam logic [CNT_W-1:0]  FIRST    = '0;
    localparam logic [RATE_W-1:0] RATE_ZERO = '0;

    // Parameter check
    if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
        $error("sprc_core: DATA_W must lie in 2..32");
    end
    if (RATE_W < 1 || RATE_W > 16) begin : g_bad_rate
        $error("sprc_core: RATE_W must lie in 1..16");
    end

    typedef struct packed {
        logic [15:0]            ctrl;
        logic [RATE_W-1:0]      rate;
        logic [DATA_W-1:0]      tx_buf;
        logic                   tx_full;
        logic [DATA_W-1:0]      rx_buf;
        logic                   rbf;
        logic                   ovf;
        sprc_pkg::sprc_evt_t    evt;
        sprc_pkg::sprc_mstate_t ms;
        logic [RATE_W-1:0]      cnt;
        logic [CNT_W-1:0]       bits;
        logic [DATA_W-1:0]      shift;
        logic                   sck;
        logic                   sck_oe;
        logic                   sdo;
        logic                   s_seen;
        logic                   wake;
    } sprc_st_t;

    typedef struct packed {
        logic [DATA_W-1:0] shift;
        logic [CNT_W-1:0]  bits;
        logic [DATA_W-1:0] word;
        logic [DATA_W-1:0] txs;
        logic              tog;
    } sprc_sl_t;

    sprc_st_t st_reg;
    sprc_st_t st_next;
    sprc_sl_t sl_reg;
    sprc_sl_t sl_next;

    logic       any_rst;
    logic [1:0] sync_q;
    logic       halt;
    logic       master_on;
    logic       slave_on;
    logic       slave_evt;

    // Every reset source acts the same on this block
    assign any_rst = reset_i | por_reset_i | wdt_reset_i;                 // see [RQ15] see [RQ16]

    // Master input data and slave completion toggle into the system clock
    sprc_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock_i (clock_i),
        .reset_i (any_rst),
        .d_i     ({sdi_i, sl_reg.tog}),
        .q_o     (sync_q)
    );

    // Role and power decode
    assign master_on = st_reg.ctrl[sprc_pkg::CTRL_ON_BIT] & st_reg.ctrl[sprc_pkg::CTRL_MASTER_BIT];
    assign slave_on  = st_reg.ctrl[sprc_pkg::CTRL_ON_BIT] & ~st_reg.ctrl[sprc_pkg::CTRL_MASTER_BIT];
    assign halt      = pwr_i.sleep | (pwr_i.idle & st_reg.ctrl[sprc_pkg::CTRL_STOP_BIT]); // see [RQ9]
    assign slave_evt = sync_q[0] != st_reg.s_seen;

    // Slave shifter on the outside clock, untouched by sleep or idle
    always_comb begin
        sl_next = sl_reg;
        if (ss_n_i) begin
            sl_next.bits = FIRST;
        end else begin
            sl_next.shift = {sl_reg.shift[DATA_W-2:0], sdi_i};            // see [RQ5] see [RQ10]
            sl_next.txs   = {sl_reg.txs[DATA_W-2:0], 1'b0};
            sl_next.bits  = sl_reg.bits + 1'b1;
            if (sl_reg.bits == LAST_BIT) begin
                sl_next.word = {sl_reg.shift[DATA_W-2:0], sdi_i};
                sl_next.txs  = st_reg.tx_buf;
                sl_next.tog  = ~sl_reg.tog;
                sl_next.bits = FIRST;
            end
        end
    end

    // Slave register; cleared only by a reset, never by a power change
    always_ff @(posedge sck_i or posedge any_rst) begin
        if (any_rst) begin
            sl_reg <= '0;                                                 // see [RQ13]
        end else begin
            sl_reg <= sl_next;                                            // see [RQ8]
        end
    end

    // Main state update
    always_comb begin
        logic              rx_done;
        logic [DATA_W-1:0] rx_word;
        logic [DATA_W-1:0] shifted;
        rx_done = 1'b0;
        rx_word = st_reg.shift;
        shifted = {st_reg.shift[DATA_W-2:0], sync_q[1]};
        st_next = st_reg;
        st_next.sck_oe = master_on;

        // Configuration writes
        if (ctrl_wr_i) begin
            st_next.ctrl = ctrl_data_i;
        end
        if (rate_wr_i) begin
            st_next.rate = rate_data_i;
        end

        // Software clears go first so that a same-cycle set wins
        st_next.evt = st_reg.evt & ~evt_clr_i;
        if (evt_clr_i.error) begin
            st_next.ovf = 1'b0;
        end
        if (rx_rd_i && !pwr_i.debug) begin
            st_next.rbf = 1'b0;                                           // see [RQ11]
        end
        if (tx_wr_i && !st_reg.tx_full) begin
            st_next.tx_buf  = tx_data_i;
            st_next.tx_full = 1'b1;
        end

        // Master sequencer
        case (st_reg.ms)
            sprc_pkg::M_IDLE: begin
                st_next.cnt = RATE_ZERO;
                st_next.sck = 1'b0;
                if (master_on && !halt && st_reg.tx_full) begin           // see [RQ3]
                    st_next.shift   = st_reg.tx_buf;
                    st_next.sdo     = st_reg.tx_buf[DATA_W-1];
                    st_next.tx_full = 1'b0;
                    st_next.evt.tx  = 1'b1;                               // see [RQ17]
                    st_next.bits    = FIRST;
                    st_next.ms      = sprc_pkg::M_RUN;
                end
            end
            sprc_pkg::M_RUN: begin
                if (halt || !master_on) begin
                    st_next.ms  = sprc_pkg::M_IDLE;                       // see [RQ2] see [RQ18]
                    st_next.cnt = RATE_ZERO;                              // see [RQ1]
                    st_next.sck = 1'b0;
                end else if (st_reg.cnt != st_reg.rate) begin
                    st_next.cnt = st_reg.cnt + 1'b1;
                end else begin
                    st_next.cnt = RATE_ZERO;
                    st_next.sck = ~st_reg.sck;
                    if (st_reg.sck) begin
                        st_next.shift = shifted;
                        st_next.sdo   = shifted[DATA_W-1];
                        st_next.bits  = st_reg.bits + 1'b1;
                        if (st_reg.bits == LAST_BIT) begin
                            rx_done    = 1'b1;
                            rx_word    = shifted;
                            st_next.ms = sprc_pkg::M_IDLE;
                        end
                    end
                end
            end
            default: begin
                st_next.ms = sprc_pkg::M_IDLE;
            end
        endcase

        // Slave word handed over from the link clock
        if (slave_evt) begin
            st_next.s_seen = sync_q[0];
            if (slave_on) begin
                rx_done = 1'b1;
                rx_word = sl_reg.word;
                if (st_reg.tx_full) begin
                    st_next.tx_full = 1'b0;
                    st_next.evt.tx  = 1'b1;
                end
            end
        end

        // Received word lands in the buffer or overflows
        if (rx_done) begin
            if (st_next.rbf) begin
                st_next.ovf       = 1'b1;
                st_next.evt.error = 1'b1;                                 // see [RQ17]
            end else begin
                st_next.rx_buf = rx_word;
                st_next.rbf    = 1'b1;                                    // see [RQ6]
                st_next.evt.rx = 1'b1;                                    // see [RQ6] see [RQ17]
            end
        end

        // Wake request from a receive event while powered down
        st_next.wake = (pwr_i.sleep | pwr_i.idle) & st_next.evt.rx       // see [RQ7]
                     & st_next.ctrl[sprc_pkg::CTRL_RXEN_BIT]
                     & (st_next.ctrl[sprc_pkg::CTRL_PRIO_LSB +: sprc_pkg::PRIO_W] > cpu_prio_i);

        // Any reset empties buffers and clears control, status and divider
        if (any_rst) begin
            st_next      = '0;                                            // see [RQ12] see [RQ13]
            st_next.ctrl = sprc_pkg::CTRL_RESET;                          // see [RQ14]
        end
    end

    // Main state register
    always_ff @(posedge clock_i) begin
        st_reg <= st_next;
    end

    // Outputs straight from state flip-flops
    assign ctrl_o      = st_reg.ctrl;
    assign rx_data_o   = st_reg.rx_buf;
    assign evt_o       = st_reg.evt;
    assign wake_o      = st_reg.wake;
    assign sck_o       = st_reg.sck;
    assign sck_oe_o    = st_reg.sck_oe;
    assign sdo_o       = st_reg.sdo;
    assign sdo_oe_o    = st_reg.sck_oe;
    assign sdo_slave_o = sl_reg.txs[DATA_W-1];

    // Status word assembled from flag flip-flops
    always_comb begin
        status_o                          = sprc_pkg::STAT_RESET;
        status_o[sprc_pkg::STAT_RBF_BIT]  = st_reg.rbf;
        status_o[sprc_pkg::STAT_TBF_BIT]  = st_reg.tx_full;
        status_o[sprc_pkg::STAT_OVF_BIT]  = st_reg.ovf;
        status_o[sprc_pkg::STAT_BUSY_BIT] = st_reg.ms == sprc_pkg::M_RUN;
    end

    // Checks on the system clock
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (any_rst);

    a_sleep_stops_master: assert property ( // see [RQ1] see [RQ2]
        st_reg.ms == sprc_pkg::M_RUN && pwr_i.sleep
        |=> st_reg.ms == sprc_pkg::M_IDLE && !st_reg.sck && st_reg.cnt == RATE_ZERO
    ) else $error("master kept running in sleep");

    a_no_start_sleep: assert property ( // see [RQ3]
        st_reg.ms == sprc_pkg::M_IDLE && pwr_i.sleep |=> st_reg.ms == sprc_pkg::M_IDLE
    ) else $error("master transfer started in sleep");

    a_abort_no_rx: assert property ( // see [RQ18]
        st_reg.ms == sprc_pkg::M_RUN && halt && !slave_evt && !st_reg.rbf
        |=> !st_reg.rbf && !$rose(st_reg.evt.rx)
    ) else $error("aborted word raised a receive flag");

    a_slave_rx_flag: assert property ( // see [RQ5] see [RQ6]
        slave_evt && slave_on && !st_reg.rbf && !any_rst
        |=> st_reg.rbf && st_reg.evt.rx && rx_data_o == $past(sl_reg.word)
    ) else $error("slave word did not set buffer full and event");

    a_wake_cond: assert property ( // see [RQ7]
        pwr_i.sleep && st_reg.evt.rx && !evt_clr_i.rx && !ctrl_wr_i
        && st_reg.ctrl[sprc_pkg::CTRL_RXEN_BIT]
        && st_reg.ctrl[sprc_pkg::CTRL_PRIO_LSB +: sprc_pkg::PRIO_W] > cpu_prio_i
        |=> wake_o
    ) else $error("wake missing for enabled receive event");

    a_regs_kept: assert property ( // see [RQ8]
        !ctrl_wr_i && !rate_wr_i && $changed(pwr_i.sleep) |=> $stable(ctrl_o) && $stable(st_reg.rate)
    ) else $error("sleep change altered configuration");

    a_idle_runs_on: assert property ( // see [RQ9]
        st_reg.ms == sprc_pkg::M_RUN && master_on && pwr_i.idle && !pwr_i.sleep
        && !st_reg.ctrl[sprc_pkg::CTRL_STOP_BIT] && st_reg.bits == FIRST
        |=> st_reg.ms == sprc_pkg::M_RUN
    ) else $error("master stopped in idle with stop bit clear");

    a_debug_read_kept: assert property ( // see [RQ11]
        pwr_i.debug && rx_rd_i && st_reg.rbf |=> st_reg.rbf
    ) else $error("debug read changed buffer full flag");

    a_reset_clears: assert property ( // see [RQ12] see [RQ13] see [RQ14]
        disable iff (1'b0)
        any_rst |=> ctrl_o == sprc_pkg::CTRL_RESET && status_o == sprc_pkg::STAT_RESET
        && st_reg.cnt == RATE_ZERO && st_reg.rate == RATE_ZERO && !sck_o
    ) else $error("reset left state behind");

    // Main scenarios
    c_master_word: cover property (st_reg.ms == sprc_pkg::M_RUN ##1 $rose(st_reg.evt.rx));
    c_slave_sleep: cover property (pwr_i.sleep && slave_on && slave_evt);
    c_sleep_abort: cover property (st_reg.ms == sprc_pkg::M_RUN && pwr_i.sleep);
    c_wake:        cover property ($rose(wake_o));

endmodule

/* test/sprc_peer.sv */
`timescale 1ns/10ps
module sprc_peer (
    // Pins driven by the device, master side and slave data out
    input  wire logic sck_m_i,
    input  wire logic sdo_m_i,
    input  wire logic sdo_s_i,
    // Pins driven toward the device
    output logic      sck_o,
    output logic      ss_n_o,
    output logic      sdi_o
);
    logic [7:0] txw;
    logic [7:0] got;
    int         cnt;

    // Link parked: clock low, not selected
    initial begin
        sck_o  = 1'b0;
        ss_n_o = 1'b1;
        sdi_o  = 1'b0;
        txw    = 8'h00;
        cnt    = 0;
    end

    // Slave answer: take the master's bit on each rising edge
    always @(posedge sck_m_i) begin
        got = {got[6:0], sdo_m_i};
    end

    // Next bit on each falling edge; released after the last one: show the inverse
    always @(negedge sck_m_i) begin
        cnt = cnt + 1;
        if (cnt >= 8) begin
            sdi_o = ~sdi_o;
        end else begin
            sdi_o = txw[7];
            txw   = {txw[6:0], 1'b0};
        end
    end

    // Arm the word answered in the next master frame; its first bit stands at once
    task automatic load(input logic [7:0] w);
        sdi_o = w[7];
        txw   = {w[6:0], 1'b0};
        cnt   = 0;
    endtask

    // Act as outside master: one selected word, clock runs only inside it
    task automatic send(input logic [7:0] w);
        ss_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sdi_o = w[i];
            #7.5 got = {got[6:0], sdo_s_i};
            sck_o = 1'b1;
            #7.5 sck_o = 1'b0;
        end
        #7.5 ss_n_o = 1'b1;
        sdi_o = ~sdi_o;
    endtask
endmodule

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    localparam logic [15:0] C_ON  = 16'h0001 << sprc_pkg::CTRL_ON_BIT;
    localparam logic [15:0] C_STP = 16'h0001 << sprc_pkg::CTRL_STOP_BIT;
    localparam logic [15:0] C_MST = 16'h0001 << sprc_pkg::CTRL_MASTER_BIT;
    localparam logic [15:0] C_RXE = 16'h0001 << sprc_pkg::CTRL_RXEN_BIT;

    logic                clock_i = 1'b0;
    logic                reset_i = 1'b1;
    logic                por_reset_i = 1'b0;
    logic                wdt_reset_i = 1'b0;
    logic                ctrl_wr_i = 1'b0;
    logic [15:0]         ctrl_data_i = 16'h0000;
    logic                rate_wr_i = 1'b0;
    logic [7:0]          rate_data_i = 8'h00;
    logic                tx_wr_i = 1'b0;
    logic [7:0]          tx_data_i = 8'h00;
    logic                rx_rd_i = 1'b0;
    sprc_pkg::sprc_evt_t evt_clr_i = 3'b000;
    sprc_pkg::sprc_pwr_t pwr_i = 3'b000;
    logic [2:0]          cpu_prio_i = 3'h0;
    logic [15:0]         ctrl_o;
    logic [15:0]         status_o;
    logic [7:0]          rx_data_o;
    sprc_pkg::sprc_evt_t evt_o;
    logic                wake_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o, sdo_slave_o;
    logic                sck_i, ss_n_i, sdi_i, rx_seen;
    logic [7:0]          rnd = 8'h4b;
    logic [7:0]          t;
    logic [7:0]          exp_q[$];
    int                  err_count = 0;
    int                  checks = 0;
    int                  cyc = 0;

    sprc_core DUT (.clock_i, .reset_i, .por_reset_i, .wdt_reset_i, .ctrl_wr_i, .ctrl_data_i,
        .rate_wr_i, .rate_data_i, .tx_wr_i, .tx_data_i, .rx_rd_i, .evt_clr_i, .pwr_i,
        .cpu_prio_i, .ctrl_o, .status_o, .rx_data_o, .evt_o, .wake_o, .sck_i, .sck_o,
        .sck_oe_o, .ss_n_i, .sdi_i, .sdo_o, .sdo_oe_o, .sdo_slave_o);

    sprc_peer peer (.sck_m_i(sck_o), .sdo_m_i(sdo_o), .sdo_s_i(sdo_slave_o),
        .sck_o(sck_i), .ss_n_o(ss_n_i), .sdi_o(sdi_i));

    // System clock and hang guard
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    // Each new receive event is matched to the oldest expected word
    always @(posedge clock_i) begin
        if (evt_o.rx === 1'b1 && rx_seen !== 1'b1) begin
            if (exp_q.size() == 0) chk("rx event", 16'h0, 16'h1);
            else chk("rx word", {8'h0, exp_q.pop_front()}, {8'h0, rx_data_o});
        end
        rx_seen <= evt_o.rx;
    end

    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic cfg(input logic [15:0] c);
        ctrl_data_i = c;
        ctrl_wr_i = 1'b1;
        cyc_n(1);
        ctrl_wr_i = 1'b0;
    endtask

    task automatic put(input logic [7:0] d);
        tx_data_i = d;
        tx_wr_i = 1'b1;
        cyc_n(1);
        tx_wr_i = 1'b0;
    endtask

    task automatic rd_clr();
        rx_rd_i = 1'b1;
        evt_clr_i = 3'b011;
        cyc_n(1);
        rx_rd_i = 1'b0;
        evt_clr_i = 3'b000;
    endtask

    task automatic arm();
        rnd = nxt(rnd);
        peer.load(rnd);
        exp_q.push_back(rnd);
    endtask

    task automatic wait_rbf();
        for (int n = 0; n < 400 && status_o[0] !== 1'b1; n++) cyc_n(1);
        chk("rx full", 16'h1, 16'(status_o[0]));
    endtask

    task automatic fin(input logic [7:0] d);
        wait_rbf();
        chk("word sent", {8'h0, d}, {8'h0, peer.got});
        rd_clr();
    endtask

    task automatic wrap_up();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial begin
        cyc_n(6);
        reset_i = 1'b0;
        chk("ctrl at start", sprc_pkg::CTRL_RESET, ctrl_o);
        chk("status at start", sprc_pkg::STAT_RESET, status_o);
        for (int k = 0; k < 4; k++) begin
            rate_data_i = 8'h03;
            rate_wr_i = 1'b1;
            cyc_n(1);
            rate_wr_i = 1'b0;
            cfg(C_ON | C_MST);
            if (k == 3) break;
            rnd = nxt(rnd);
            put(rnd);
            cyc_n(15);
            {wdt_reset_i, por_reset_i, reset_i} = 3'b001 << k;
            cyc_n(4);
            {wdt_reset_i, por_reset_i, reset_i} = 3'b000;
            chk("ctrl cleared", 16'h0, ctrl_o);
            chk("status cleared", 16'h0, status_o);
            chk("events cleared", 16'h0, 16'(evt_o));
            chk("clock parked", 16'h0, 16'(sck_o));
        end
        // Idle with stop clear: master keeps running, words finish before sleep
        pwr_i = 3'b010;
        for (int k = 0; k < 2; k++) begin
            arm();
            rnd = nxt(rnd);
            t = rnd;
            put(t);
            cyc_n(2);
            chk("tx event", 16'h1, 16'(evt_o.tx));
            fin(t);
        end
        // Halt mid-word by sleep, then by idle with stop set
        for (int v = 0; v < 2; v++) begin
            pwr_i = 3'b000;
            cfg(C_ON | C_MST | (v == 1 ? C_STP : 16'h0));
            rnd = nxt(rnd);
            put(rnd);
            cyc_n(20);
            pwr_i = (v == 1) ? 3'b010 : 3'b100;
            cyc_n(2);
            for (int i = 0; i < 30; i++) begin
                chk("halted clock", 16'h0, 16'(sck_o));
                cyc_n(1);
            end
            chk("abort state", 16'h0, status_o & 16'h0801);
            rnd = nxt(rnd);
            t = rnd;
            put(t);
            cyc_n(8);
            chk("no start", 16'h0002, status_o & 16'h0802);
            arm();
            pwr_i = 3'b000;
            fin(t);
        end
        // Slave word through sleep raises event and wake
        cfg(C_ON | C_RXE | 16'h0005);
        cpu_prio_i = 3'h2;
        rnd = nxt(rnd);
        t = rnd;
        put(t);
        pwr_i = 3'b100;
        arm();
        peer.send(rnd);
        wait_rbf();
        cyc_n(2);
        chk("wake", 16'h1, 16'(wake_o));
        chk("ctrl kept", C_ON | C_RXE | 16'h0005, ctrl_o);
        rd_clr();
        // Slave in idle with stop set, priority not above the processor
        cfg(C_ON | C_STP | C_RXE | 16'h0005);
        cpu_prio_i = 3'h5;
        pwr_i = 3'b010;
        arm();
        peer.send(rnd);
        wait_rbf();
        cyc_n(2);
        chk("no wake", 16'h0, 16'(wake_o));
        chk("slave out", {8'h0, t}, {8'h0, peer.got});
        // Reads in debug leave the full flag alone
        pwr_i = 3'b001;
        rx_rd_i = 1'b1;
        cyc_n(1);
        rx_rd_i = 1'b0;
        cyc_n(1);
        chk("debug read", 16'h1, 16'(status_o[0]));
        // Word arriving on a full buffer raises overflow and the error event
        peer.send(rnd);
        cyc_n(8);
        chk("overflow", 16'h0041, status_o & 16'h0041);
        chk("error event", 16'h0004, 16'(evt_o) & 16'h0004);
        pwr_i = 3'b000;
        rd_clr();
        chk("read clears", 16'h0, 16'(status_o[0]));
        chk("queue drained", 16'h0, 16'(exp_q.size()));
        wrap_up();
    end
endmodule
